//--- link_opt_pkg.sv
// package: register map, field positions and types of the transmit option block
package link_opt_pkg;
   localparam logic [11:0] OFS_SYNC_SYM = 12'h060;
   localparam logic [11:0] OFS_CKS_TGEN = 12'h061;
   localparam logic [11:0] OFS_USER01 = 12'h100;
   localparam logic [11:0] OFS_USER23 = 12'h104;
   localparam logic [11:0] OFS_CKS_VAL = 12'h108;
   localparam logic [7:0] RST_SYNC_SYM = 8'h00;
   localparam logic [7:0] RST_CKS_TGEN = 8'h00;
   localparam logic [31:0] RST_USER = 32'h0000_0000;
   localparam int SYNC_MODE_HI = 7;
   localparam int SYNC_MODE_LO = 6;
   localparam int SYNC_INV_BIT = 5;
   localparam int BYPASS_BIT = 2;
   localparam int SYM_INV_BIT = 1;
   localparam int MIRROR_BIT = 0;
   localparam int CKS_DIS_BIT = 7;
   localparam int CKS_MODE_BIT = 6;
   localparam int INJ_HI = 5;
   localparam int INJ_LO = 4;
   localparam int TMODE_HI = 3;
   localparam int TMODE_LO = 0;
   localparam logic [1:0] SYNC_NORMAL = 2'h0;
   localparam logic [1:0] SYNC_FORCE = 2'h2;
   localparam logic [1:0] SYNC_IGNORE = 2'h3;
   localparam logic [1:0] INJ_SAMPLE = 2'h0;
   localparam logic [1:0] INJ_SYMBOL = 2'h1;
   localparam logic [1:0] INJ_BYTE = 2'h2;
   localparam logic [3:0] TM_NORMAL = 4'h0;
   localparam logic [3:0] TM_CHECKER = 4'h1;
   localparam logic [3:0] TM_TOGGLE = 4'h2;
   localparam logic [3:0] TM_PN = 4'h3;
   localparam logic [3:0] TM_USER_REP = 4'h5;
   localparam logic [3:0] TM_USER_ONE = 4'h6;
   localparam logic [3:0] TM_RAMP = 4'h7;
   localparam logic [3:0] TM_RPAT = 4'h8;
   localparam logic [3:0] TM_JSPAT = 4'ha;
   localparam logic [3:0] TM_JTSPAT = 4'hb;
   localparam logic [22:0] PN_SEED = 23'h7f_ffff;
   localparam logic [9:0] K28_5_RD_NEG = 10'h0fa;
   localparam int CFG_BYTES = 4;
   localparam int CFG_FIELDS = 6;
   // datapath word: sample, scrambler byte and encoded symbol for one cycle
   typedef struct packed {
      logic [15:0] sample;
      logic [7:0] byte_d;
      logic [9:0] symbol;
   } lane_data_t;
   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
   } ahb_req_t;
endpackage

//--- link_tx_opt.sv
// transmit option block: sync request handling, symbol options, checksum, test patterns
`timescale 1ns/100ps
`default_nettype none
module link_tx_opt
   import link_opt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_pdn,
   input wire logic sync_request_in,
   input wire logic [15:0] sample_in,
   input wire logic [31:0] cfg_bytes,
   input wire logic [29:0] cfg_fields,
   output logic [15:0] sample_out,
   input wire logic [7:0] scr_byte_in,
   output logic [7:0] scr_byte_out,
   input wire logic [9:0] enc_symbol_in,
   output logic [9:0] phy_symbol,
   output logic [7:0] cks_out,
   output logic send_k28_5
);
   logic [7:0] ctl_sym_r;
   logic [7:0] ctl_tg_r;
   logic [31:0] user01_r;
   logic [31:0] user23_r;
   ahb_req_t req_r;
   logic req_valid_r;
   logic [22:0] pn_r;
   logic [15:0] ramp_r;
   logic [1:0] uidx_r;
   logic udone_r;
   logic toggle_r;
   logic [3:0] seq_r;

   // bus decode
   wire logic take_req = hsel && hready && htrans[1];
   wire logic wr_now = req_valid_r && req_r.hwrite;
   // offsets are word indexes; byte address is four times the index
   wire logic [11:0] wr_ofs = req_r.haddr[13:2];
   wire logic [11:0] rd_ofs = haddr[13:2];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         req_valid_r <= 1'b0;
         req_r <= '0;
      end else begin
         req_valid_r <= take_req;
         req_r <= '{htrans, haddr, hwrite, hsize, hsel};
      end
   end

   // writes are taken at any time; software owns power-down ordering
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctl_sym_r <= RST_SYNC_SYM;
         ctl_tg_r <= RST_CKS_TGEN;
         user01_r <= RST_USER;
         user23_r <= RST_USER;
      end else if (wr_now) begin
         if (wr_ofs == OFS_SYNC_SYM) ctl_sym_r <= hwdata[7:0] & 8'he7;
         if (wr_ofs == OFS_CKS_TGEN) ctl_tg_r <= hwdata[7:0];
         if (wr_ofs == OFS_USER01) user01_r <= hwdata;
         if (wr_ofs == OFS_USER23) user23_r <= hwdata;
      end
   end

   // read data sampled in the address phase, shown in the data phase; zero wait
   logic [31:0] rd_nxt;
   assign rd_nxt = (rd_ofs == OFS_SYNC_SYM) ? {24'h000000, ctl_sym_r} :
                   (rd_ofs == OFS_CKS_TGEN) ? {24'h000000, ctl_tg_r} :
                   (rd_ofs == OFS_USER01) ? user01_r :
                   (rd_ofs == OFS_USER23) ? user23_r :
                   (rd_ofs == OFS_CKS_VAL) ? {24'h000000, cks_out} : 32'h0000_0000;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (take_req && !hwrite) begin
         hrdata <= rd_nxt;
      end
   end

   // fields
   wire logic [1:0] sync_mode = ctl_sym_r[SYNC_MODE_HI:SYNC_MODE_LO];
   wire logic sync_inv = ctl_sym_r[SYNC_INV_BIT];
   wire logic bypass = ctl_sym_r[BYPASS_BIT];
   wire logic sym_inv = ctl_sym_r[SYM_INV_BIT];
   wire logic mirror = ctl_sym_r[MIRROR_BIT];
   wire logic cks_dis = ctl_tg_r[CKS_DIS_BIT];
   wire logic cks_mode = ctl_tg_r[CKS_MODE_BIT];
   wire logic [1:0] inj = ctl_tg_r[INJ_HI:INJ_LO];
   wire logic [3:0] tmode = ctl_tg_r[TMODE_HI:TMODE_LO];

   // sync request handling
   wire logic sync_eff = sync_request_in ^ sync_inv;
   wire logic sync_use = (sync_mode == SYNC_IGNORE) ? 1'b0 :
                         (sync_mode == SYNC_FORCE) ? 1'b1 : sync_eff;
   wire logic k_nxt = !link_pdn && sync_use;

   // checksum
   logic [7:0] sum_bytes;
   logic [7:0] sum_fields;
   always_comb begin
      sum_bytes = 8'h00;
      sum_fields = 8'h00;
      for (int i = 0; i < CFG_BYTES; i++) sum_bytes = sum_bytes + cfg_bytes[i*8 +: 8];
      for (int j = 0; j < CFG_FIELDS; j++) sum_fields = sum_fields + {3'h0, cfg_fields[j*5 +: 5]};
   end
   wire logic [7:0] cks_nxt = cks_dis ? 8'h00 : (cks_mode ? sum_fields : sum_bytes);

   // pattern generators
   wire logic pn_fb = pn_r[22] ^ pn_r[17];
   // restart on the write itself, so the first cycle of a new mode starts at word 0
   wire logic tm_chg = wr_now && (wr_ofs == OFS_CKS_TGEN);
   always_ff @(posedge clk_sys) begin
      if (reset || tm_chg) begin
         pn_r <= PN_SEED;
         ramp_r <= 16'h0000;
         uidx_r <= 2'h0;
         udone_r <= 1'b0;
         toggle_r <= 1'b0;
         seq_r <= 4'h0;
      end else begin
         pn_r <= {pn_r[21:0], pn_fb};
         ramp_r <= ramp_r + 16'h0001;
         toggle_r <= !toggle_r;
         uidx_r <= uidx_r + 2'h1;
         if (uidx_r == 2'h3) udone_r <= 1'b1;
         seq_r <= seq_r + 4'h1;
      end
   end
   wire logic [15:0] user_word = (uidx_r == 2'h0) ? user01_r[15:0] :
                                 (uidx_r == 2'h1) ? user01_r[31:16] :
                                 (uidx_r == 2'h2) ? user23_r[15:0] : user23_r[31:16];
   // one 16-bit pattern; narrower points take the most significant bits
   logic [15:0] pat;
   always_comb begin
      unique case (tmode)
         TM_CHECKER: pat = toggle_r ? 16'haaaa : 16'h5555;
         TM_TOGGLE: pat = toggle_r ? 16'hffff : 16'h0000;
         TM_PN: pat = pn_r[22:7];
         TM_USER_REP: pat = user_word;
         TM_USER_ONE: pat = udone_r ? 16'h0000 : user_word;
         TM_RAMP: pat = ramp_r;
         // symbol sequences: RPAT alternates K28.5 with 0x1be, JSPAT alternates two fill symbols, JTSPAT sends K28.5 then PN
         TM_RPAT: pat = {seq_r[0] ? 10'h1be : 10'h0fa, 6'h00};
         TM_JSPAT: pat = {seq_r[1] ? 10'h3ea : 10'h115, 6'h00};
         TM_JTSPAT: pat = {(seq_r[3:2] == 2'h0) ? K28_5_RD_NEG : pn_r[22:13], 6'h00};
         default: pat = 16'h0000;
      endcase
   end
   wire logic tg_on = tmode != TM_NORMAL;
   wire logic is_sym_seq = tmode == TM_RPAT || tmode == TM_JSPAT || tmode == TM_JTSPAT;

   // injection: downstream stages see the replaced stream, except bypass, which builds the symbol from scr_byte_in
   wire logic [15:0] samp_nxt = (tg_on && inj == INJ_SAMPLE && !is_sym_seq) ?
                                pat : sample_in;
   wire logic [7:0] byte_nxt = (tg_on && inj == INJ_BYTE && !is_sym_seq) ?
                               pat[15:8] : scr_byte_in;
   wire logic inj_sym = tg_on && (inj == INJ_SYMBOL || is_sym_seq);
   wire logic [9:0] enc_sel = bypass ? {2'h0, scr_byte_in} : enc_symbol_in;
   wire logic [9:0] sym_raw = inj_sym ? pat[15:6] : enc_sel;
   wire logic [9:0] sym_inv_d = sym_inv ? ~sym_raw : sym_raw;
   logic [9:0] sym_mir;
   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : g_mir
         assign sym_mir[g] = mirror ? sym_inv_d[9-g] : sym_inv_d[g];
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sample_out <= 16'h0000;
         scr_byte_out <= 8'h00;
         phy_symbol <= 10'h000;
         cks_out <= 8'h00;
         send_k28_5 <= 1'b0;
      end else begin
         sample_out <= samp_nxt;
         scr_byte_out <= byte_nxt;
         phy_symbol <= sym_mir;
         cks_out <= cks_nxt;
         send_k28_5 <= k_nxt;
      end
   end

   // bus side: no wait states, always okay, holes read as zero
   wire logic rd_mapped = rd_ofs == OFS_SYNC_SYM || rd_ofs == OFS_CKS_TGEN ||
                          rd_ofs == OFS_USER01 || rd_ofs == OFS_USER23 ||
                          rd_ofs == OFS_CKS_VAL;

   a_bus_ready: assert property (@(posedge clk_sys) disable iff (reset)
      hreadyout && !hresp) else $error("bus not ready or not okay");

   a_bus_hole: assert property (@(posedge clk_sys) disable iff (reset)
      (take_req && !hwrite && !rd_mapped) |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_ctl_unused: assert property (@(posedge clk_sys) disable iff (reset)
      ctl_sym_r[4:3] == 2'h0) else $error("unused control bits set");

   // sync request path
   a_sync_ignore: assert property (@(posedge clk_sys) disable iff (reset)
      sync_mode == SYNC_IGNORE |=> !send_k28_5) else $error("sync not ignored");

   a_sync_force: assert property (@(posedge clk_sys) disable iff (reset)
      (sync_mode == SYNC_FORCE && !link_pdn) |=> send_k28_5) else $error("sync not forced");

   a_sync_polarity: assert property (@(posedge clk_sys) disable iff (reset)
      (sync_mode == SYNC_NORMAL && !link_pdn) |=>
      send_k28_5 == ($past(sync_inv) ? !$past(sync_request_in) : $past(sync_request_in)))
      else $error("sync polarity wrong");

   a_sync_powered: assert property (@(posedge clk_sys) disable iff (reset)
      link_pdn |=> !send_k28_5) else $error("sync request while powered down");

   // symbol options, checked on the registered symbol
   a_bypass_top: assert property (@(posedge clk_sys) disable iff (reset)
      (bypass && !inj_sym && !sym_inv) |=> phy_symbol[9:8] == 2'h0 || $past(mirror))
      else $error("bypass top bits");

   a_sym_invert: assert property (@(posedge clk_sys) disable iff (reset)
      (sym_inv && !mirror && !bypass && !inj_sym) |=> phy_symbol == ~$past(enc_symbol_in))
      else $error("symbol not inverted");

   a_sym_mirror: assert property (@(posedge clk_sys) disable iff (reset)
      (mirror && !sym_inv && !bypass && !inj_sym) |=>
      phy_symbol[9] == $past(enc_symbol_in[0]) && phy_symbol[0] == $past(enc_symbol_in[9]))
      else $error("symbol not mirrored");

   // checksum
   a_cks_zero: assert property (@(posedge clk_sys) disable iff (reset)
      cks_dis |=> cks_out == 8'h00) else $error("checksum not zero");

   a_cks_bytes: assert property (@(posedge clk_sys) disable iff (reset)
      (!cks_dis && !cks_mode) |=> cks_out ==
      $past(cfg_bytes[7:0] + cfg_bytes[15:8] + cfg_bytes[23:16] + cfg_bytes[31:24]))
      else $error("byte checksum wrong");

   // pattern generators; invert and mirror keep complements and inequality intact
   a_checker_flip: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_CHECKER && inj == INJ_SYMBOL && !wr_now)[*2] |=>
      phy_symbol == ~$past(phy_symbol)) else $error("checkerboard not alternating");

   a_toggle_flip: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_TOGGLE && inj == INJ_BYTE && !wr_now)[*2] |=>
      scr_byte_out == ~$past(scr_byte_out)) else $error("word toggle not alternating");

   a_user_once: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_USER_ONE && udone_r && inj == INJ_SAMPLE) |=> sample_out == 16'h0000)
      else $error("single user not zero");

   a_user_repeat: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_USER_REP && uidx_r == 2'h0 && !tm_chg) ##1 !tm_chg[*4] |-> uidx_r == 2'h0)
      else $error("user sequence period");

   a_inject_byte: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_USER_REP && inj == INJ_BYTE && uidx_r == 2'h0) |=>
      scr_byte_out == $past(user01_r[15:8])) else $error("byte injection wrong");

   a_rpat_alt: assert property (@(posedge clk_sys) disable iff (reset)
      (tmode == TM_RPAT && !wr_now)[*2] |=> phy_symbol != $past(phy_symbol))
      else $error("modified pattern not alternating");

   a_sample_inject: assert property (@(posedge clk_sys) disable iff (reset)
      (!tg_on || inj != INJ_SAMPLE) |=> sample_out == $past(sample_in))
      else $error("sample passthrough");

   c_force: cover property (@(posedge clk_sys) send_k28_5);
   c_repeat: cover property (@(posedge clk_sys) tmode == TM_USER_REP && uidx_r == 2'h3);
   c_mirror: cover property (@(posedge clk_sys) mirror && sym_inv);
   c_user_done: cover property (@(posedge clk_sys) tmode == TM_USER_ONE && udone_r);
   c_sym_seq: cover property (@(posedge clk_sys) tg_on && is_sym_seq);
endmodule
`default_nettype wire

//--- rx_sync_model.sv
// receiver-side model that drives the sync request toward the transmitter
`timescale 1ns/100ps
`default_nettype none
module rx_sync_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic lost_sync,
   output logic sync_request_in
);
   // registered so the request only moves just after an edge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_request_in <= 1'b0;
      end else begin
         sync_request_in <= lost_sync;
      end
   end
endmodule
`default_nettype wire

//--- test_serial_link_tx_sync_test_options.sv
// self-checking bench for the transmit option block
`timescale 1ns/100ps
`default_nettype none
module test_serial_link_tx_sync_test_options;
   import link_opt_pkg::*;
   typedef struct packed {logic [2:0] k; logic [31:0] v;} note_t;
   logic clk_sys = 0, reset = 1, hsel = 0, hwrite = 0, link_pdn = 1, lost_sync = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, cfg_bytes = '0, rnd = 32'h47a7;
   logic [1:0] htrans = '0;
   logic [29:0] cfg_fields = '0;
   logic [15:0] sample_in = '0, sample_out;
   logic [7:0] scr_byte_in = '0, scr_byte_out, cks_out;
   logic [9:0] enc_symbol_in = '0, phy_symbol;
   logic hreadyout, hresp, sync_request_in, send_k28_5;
   logic [15:0] uw [4];
   int err_total = 0, num_checks = 0;
   note_t notes [$];
   note_t n;
   link_tx_opt link_tx_opt_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link_pdn(link_pdn), .sync_request_in(sync_request_in), .sample_in(sample_in),
      .cfg_bytes(cfg_bytes), .cfg_fields(cfg_fields), .sample_out(sample_out),
      .scr_byte_in(scr_byte_in), .scr_byte_out(scr_byte_out),
      .enc_symbol_in(enc_symbol_in), .phy_symbol(phy_symbol), .cks_out(cks_out),
      .send_k28_5(send_k28_5));
   rx_sync_model rx_sync_model_inst (.clk_sys(clk_sys), .reset(reset),
      .lost_sync(lost_sync), .sync_request_in(sync_request_in));
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [9:0] rev10(input logic [9:0] s);
      for (int i = 0; i < 10; i++) rev10[i] = s[9 - i];
   endfunction
   task automatic note(input logic [2:0] k, input logic [31:0] v);
      notes.push_back('{k, v});
   endtask
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("unexpected %0t read %h want %h", $time, got, want);
      end
   endtask
   task automatic cmp_out(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("unexpected %0t output %h want %h", $time, got, want);
      end
   endtask
   // single transfer; waits on hreadyout rather than assuming zero wait states
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] want);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0, a, 2'b00};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      if (!w) note(3'd0, want);
   endtask
   // the mode lands on the edge the write returns on; word 0 leaves on the next edge
   task automatic pat(input logic [3:0] tm, input logic [1:0] inj);
      logic [15:0] w;
      bus(1, OFS_CKS_TGEN, {24'h0, 2'b00, inj, tm}, 0);
      for (int i = 0; i < 8; i++) begin
         w = (tm == TM_USER_ONE && i > 3) ? 16'h0 : uw[i % 4];
         @(posedge clk_sys);
         if (inj == INJ_SYMBOL) note(3'd1, w[15:6]);
         else if (inj == INJ_BYTE) note(3'd5, w[15:8]);
         else note(3'd4, w);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(negedge clk_sys) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.k)
            3'd0: begin
               cmp_rd(hrdata, n.v);
               cmp_out({30'h0, hresp, hreadyout}, 32'h0000_0001);
            end
            3'd1: cmp_out({22'h0, phy_symbol}, n.v);
            3'd2: cmp_out({31'h0, send_k28_5}, n.v);
            3'd3: cmp_out({24'h0, cks_out}, n.v);
            3'd4: cmp_out({16'h0, sample_out}, n.v);
            default: cmp_out({24'h0, scr_byte_out}, n.v);
         endcase
      end
   end
   initial begin
      #100000;
      err_total++;
      conclude();
   end
   initial begin
      logic [31:0] e;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      bus(0, OFS_SYNC_SYM, 0, {24'h0, RST_SYNC_SYM});
      bus(0, OFS_CKS_TGEN, 0, {24'h0, RST_CKS_TGEN});
      bus(0, 12'h0f0, 0, 0);
      bus(1, OFS_SYNC_SYM, 32'hff, 0);
      bus(0, OFS_SYNC_SYM, 0, 32'he7);
      for (int t = 0; t < 16; t++) begin
         bus(1, OFS_CKS_TGEN, {24'h0, t[3:0], t[3:0]}, 0);
         bus(0, OFS_CKS_TGEN, 0, {24'h0, t[3:0], t[3:0]});
      end
      bus(1, OFS_CKS_TGEN, 0, 0);
      for (int o = 0; o < 8; o++) begin
         bus(1, OFS_SYNC_SYM, 32'(o), 0);
         rnd = xs(rnd);
         @(posedge clk_sys);
         enc_symbol_in <= rnd[9:0];
         scr_byte_in <= rnd[17:10];
         sample_in <= rnd[31:16];
         e = o[2] ? {24'h0, 2'b00, rnd[17:10]} : {22'h0, rnd[9:0]};
         if (o[1]) e[9:0] = ~e[9:0];
         if (o[0]) e[9:0] = rev10(e[9:0]);
         @(posedge clk_sys);
         note(3'd1, e);
         note(3'd4, rnd[31:16]);
      end
      for (int m = 0; m < 3; m++) begin
         bus(1, OFS_CKS_TGEN, {24'h0, m[1:0], 6'h0}, 0);
         rnd = xs(rnd);
         @(posedge clk_sys);
         cfg_bytes <= rnd;
         cfg_fields <= rnd[31:2];
         e = 0;
         for (int i = 0; i < 6; i++) begin
            if (m == 0 && i < 4) e = e + rnd[8 * i +: 8];
            if (m == 1) e = e + rnd[2 + 5 * i +: 5];
         end
         @(posedge clk_sys);
         note(3'd3, {24'h0, e[7:0]});
      end
      for (int j = 0; j < 16; j++) begin
         if (j[3:2] == 2'b01) continue;
         link_pdn <= 1'b1;
         bus(1, OFS_SYNC_SYM, {24'h0, j[3:1], 5'h0}, 0);
         @(posedge clk_sys);
         link_pdn <= (j == 1);
         lost_sync <= j[0];
         repeat (2) @(posedge clk_sys);
         e = (j[3:2] == 2'b11 || j == 1) ? 0 : (j[3:2] == 2'b10) ? 1 : 32'(j[0] ^ j[1]);
         note(3'd2, e);
      end
      rnd = xs(rnd);
      uw[0] = rnd[15:0];
      uw[1] = rnd[31:16];
      rnd = xs(rnd);
      uw[2] = rnd[15:0];
      uw[3] = rnd[31:16];
      bus(1, OFS_USER01, {uw[1], uw[0]}, 0);
      bus(1, OFS_USER23, {uw[3], uw[2]}, 0);
      bus(0, OFS_USER01, 0, {uw[1], uw[0]});
      pat(TM_USER_REP, INJ_SAMPLE);
      pat(TM_USER_ONE, INJ_SAMPLE);
      pat(TM_USER_REP, INJ_SYMBOL);
      pat(TM_USER_REP, INJ_BYTE);
      repeat (2) @(posedge clk_sys);
      conclude();
   end
endmodule
`default_nettype wire
